// File: bench/data_move_instr_exec_tb.sv
// self-checking bench for the data-movement instruction executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module data_move_instr_exec_tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, fetch_valid, fetch_ready, dmem_re, dmem_we, err;
    logic [15:0] fetch_word;
    logic [11:0] dmem_addr;
    logic [7:0] dmem_rdata, dmem_wdata;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_re = 0;
    int n_we = 0;
    int base;

    always #50 clk_sys = ~clk_sys;

    data_move_instr_exec i_dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .FETCH_WORD(fetch_word), .FETCH_VALID(fetch_valid), .FETCH_READY(fetch_ready), .DMEM_ADDR(dmem_addr),
        .DMEM_RE(dmem_re), .DMEM_RDATA(dmem_rdata), .DMEM_WDATA(dmem_wdata), .DMEM_WE(dmem_we));

    dmx_mem_model i_mem (.clk(clk_sys), .arst_n(arst_n), .fetch_word(fetch_word), .fetch_valid(fetch_valid),
        .fetch_ready(fetch_ready), .dmem_addr(dmem_addr), .dmem_re(dmem_re), .dmem_rdata(dmem_rdata),
        .dmem_wdata(dmem_wdata), .dmem_we(dmem_we));

    ////////////////////////////////////////////////////////////////////////////////
    // cycle ceiling and memory strobe counters
    always @(posedge clk_sys) begin
        cyc++;
        n_re += dmem_re;
        n_we += dmem_we;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d,
                       output logic e);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) err_total++;
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0, rd, err);
        `CHK(nm, exp, rd);
    endtask

    task automatic put(input logic [15:0] w);
        i_mem.prog.push_back(w);
    endtask

    // results land three edges after the take; two spare edges
    task automatic drain();
        int n;
        n = 0;
        while (i_mem.prog.size() != 0 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (5) @(posedge clk_sys);
    endtask

    task automatic exec(input logic [15:0] w);
        put(w);
        drain();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd_chk(dmx_pkg::REG_WREG, 32'h0, "wreg_rst");
        apb(1'b0, 8'h24, 32'h0, rd, err);
        `CHK("unmapped_err", 1'b1, err);
        apb(1'b1, dmx_pkg::REG_WREG, 32'hff, rd, err);
        `CHK("ro_write_err", 1'b1, err);
        apb(1'b1, dmx_pkg::REG_CTRL, 32'h1, rd, err);
        rd_chk(dmx_pkg::REG_CTRL, 32'h1, "ctrl_run");
        $display("test apb done");
        exec(16'h0e5a);
        rd_chk(dmx_pkg::REG_WREG, 32'h5a, "wreg_lit");
        exec(16'h0123);
        rd_chk(dmx_pkg::REG_BANK_SEL, 32'h23, "bank_sel_load");
        rd_chk(dmx_pkg::REG_STATUS, 32'h0, "flags_kept");
        $display("test literal done");
        base = n_we;
        exec(16'h6f45);
        `CHK("store_bank", 8'h5a, i_mem.mem[12'h345]);
        `CHK("store_one_we", 1, n_we - base);
        exec(16'h6e7f);
        `CHK("store_acc_lo", 8'h5a, i_mem.mem[12'h07f]);
        exec(16'h6e80);
        `CHK("store_acc_hi", 8'h5a, i_mem.mem[12'hf80]);
        $display("test store done");
        i_mem.mem[12'h320] = 8'h80;
        exec(16'h5120);
        rd_chk(dmx_pkg::REG_WREG, 32'h80, "fmove_w");
        rd_chk(dmx_pkg::REG_STATUS, 32'h10, "flag_neg");
        exec(16'h5230);
        rd_chk(dmx_pkg::REG_WREG, 32'h80, "fmove_back_w");
        rd_chk(dmx_pkg::REG_STATUS, 32'h04, "flag_zero");
        exec(16'h0e00);
        rd_chk(dmx_pkg::REG_STATUS, 32'h04, "lit_no_flag");
        $display("test file move done");
        exec(16'hee2f);
        rd_chk(dmx_pkg::REG_PTR2, 32'hf00, "ptr_hi_first");
        exec(16'hf0cd);
        rd_chk(dmx_pkg::REG_PTR2, 32'hfcd, "ptr_lo_second");
        for (int i = 0; i < 2; i++) begin
            put({10'h3b8, 2'(i), 4'h3});
            put(16'hf0ab);
            drain();
            rd_chk(8'(dmx_pkg::REG_PTR0 + 8'(4 * i)), 32'h3ab, "ptr_load");
        end
        rd_chk(dmx_pkg::REG_STATUS, 32'h04, "ptr_no_flag");
        apb(1'b0, dmx_pkg::REG_BAD_CNT, 32'h0, rd, err);
        base = rd;
        put(16'hee15);
        put(16'h1234);
        drain();
        rd_chk(dmx_pkg::REG_PTR1, 32'h5ab, "ptr_bad_second");
        rd_chk(dmx_pkg::REG_BAD_CNT, 32'(base + 1), "bad_count");
        put(16'hee33);
        put(16'hf0ab);
        drain();
        rd_chk(dmx_pkg::REG_PTR2, 32'hfcd, "ptr_idx3_dropped");
        rd_chk(dmx_pkg::REG_PTR1, 32'h5ab, "ptr_idx3_kept");
        $display("test pointer done");
        // destinations never program counter or stack top
        i_mem.mem[12'hfff] = 8'h77;
        put(16'hcfff);
        put(16'hf000);
        drain();
        `CHK("f2f_corner", 8'h77, i_mem.mem[12'h000]);
        i_mem.mem[12'h456] = 8'h99;
        base = n_re;
        exec(16'hc456);
        `CHK("f2f_waiting", 8'h00, i_mem.mem[12'h800]);
        exec(16'hf800);
        `CHK("f2f_late", 8'h99, i_mem.mem[12'h800]);
        `CHK("f2f_one_read", 1, n_re - base);
        exec(16'h0e3c);
        put(16'hcfe8);
        put(16'hf123);
        drain();
        `CHK("f2f_from_w", 8'h3c, i_mem.mem[12'h123]);
        put(16'hc456);
        put(16'hffe8);
        drain();
        rd_chk(dmx_pkg::REG_WREG, 32'h99, "f2f_to_w");
        rd_chk(dmx_pkg::REG_STATUS, 32'h04, "f2f_no_flag");
        $display("test file to file done");
        rd_chk(dmx_pkg::REG_EXEC_CNT, 32'h1a, "exec_count");
        test_done();
    end
endmodule // data_move_instr_exec_tb
`default_nettype wire

// File: bench/dmx_mem_model.sv
// program fetch and data memory model facing the executor
`timescale 1ns/1ps
`default_nettype none
module dmx_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // instruction fetch
    output logic [15:0] fetch_word,
    output logic fetch_valid,
    input wire logic fetch_ready,
    // data memory
    input wire logic [11:0] dmem_addr,
    input wire logic dmem_re,
    output logic [7:0] dmem_rdata,
    input wire logic [7:0] dmem_wdata,
    input wire logic dmem_we
);
    logic [15:0] prog[$];
    logic [7:0] mem [0:4095];
    logic [7:0] junk_q = 8'ha5;

    initial begin
        fetch_valid = 1'b0;
        fetch_word = 16'h0000;
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // words go out strictly in order, so two-word pairs stay adjacent
    always @(posedge clk) begin
        if (fetch_valid && fetch_ready) begin
            void'(prog.pop_front());
        end
        fetch_valid <= arst_n && (prog.size() != 0);
        // idle word changes every cycle so a stale sample cannot pass
        fetch_word <= (prog.size() != 0) ? prog[0] : ~fetch_word;
        junk_q <= ~junk_q;
        if (dmem_we) begin
            mem[dmem_addr] <= dmem_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // any of 000h..fffh answers, w at fe8h included
    assign dmem_rdata = dmem_re ? mem[dmem_addr] : junk_q;
endmodule // dmx_mem_model
`default_nettype wire

// File: rtl/data_move_instr_exec.sv
// data-movement instruction executor with apb status port
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module data_move_instr_exec (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // instruction fetch
    input wire logic [15:0] FETCH_WORD,
    input wire logic FETCH_VALID,
    output logic FETCH_READY,
    // data memory
    output logic [11:0] DMEM_ADDR,
    output logic DMEM_RE,
    input wire logic [7:0] DMEM_RDATA,
    output logic [7:0] DMEM_WDATA,
    output logic DMEM_WE
);
    ////////////////////////////////////////////////////////////////////////////////////
    // state
    logic [1:0] phase;
    logic run_q;
    logic [15:0] ir_q;
    logic iv_q;
    dmx_pkg::stage_t st_q;
    logic [7:0] w_q;
    logic [7:0] bank_sel_q;
    logic [7:0] status_q;
    logic [7:0] rd_q;
    logic [7:0] wdata_q;
    logic we_q;
    logic [1:0] ptr_idx_q;
    logic [3:0] ptr_hi_q [dmx_pkg::NUM_PTRS];
    logic [7:0] ptr_lo_q [dmx_pkg::NUM_PTRS];
    logic [31:0] exec_cnt_q;
    logic [31:0] bad_cnt_q;
    logic [31:0] prdata_q;
    logic slverr_q;

    dmx_phase_seq u_phase (
        .clk(CLK_SYS),
        .arst_n(ARST_N),
        .phase(phase)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    // decode
    wire q1 = phase == dmx_pkg::PH_Q1;
    wire q2 = phase == dmx_pkg::PH_Q2;
    wire q3 = phase == dmx_pkg::PH_Q3;
    wire q4 = phase == dmx_pkg::PH_Q4;
    wire take = FETCH_VALID && FETCH_READY;
    wire st_one = st_q == dmx_pkg::ST_ONE;
    wire st_plo = st_q == dmx_pkg::ST_PTR_LO;
    wire st_dst = st_q == dmx_pkg::ST_F2F_DST;
    wire [7:0] lit = ir_q[7:0];
    wire is_ptr = iv_q && st_one && ir_q[15:6] == dmx_pkg::OP_PTR_LOAD;
    wire is_fmv = iv_q && st_one && ir_q[15:10] == dmx_pkg::OP_FILE_MOVE;
    wire is_f2f = iv_q && st_one && ir_q[15:12] == dmx_pkg::OP_F2F_SRC;
    wire is_bnk = iv_q && st_one && ir_q[15:8] == dmx_pkg::OP_BANK_LOAD;
    wire is_lit = iv_q && st_one && ir_q[15:8] == dmx_pkg::OP_LIT_LOAD;
    wire is_sto = iv_q && st_one && ir_q[15:9] == dmx_pkg::OP_ACC_STORE;
    wire ptr2_ok = iv_q && st_plo && ir_q[15:8] == dmx_pkg::OP_PTR_LOAD2;
    wire dst_ok = iv_q && st_dst && ir_q[15:12] == dmx_pkg::OP_F2F_DST;
    wire known = is_ptr || is_fmv || is_f2f || is_bnk || is_lit || is_sto || ptr2_ok || dst_ok;
    wire dest_f = ir_q[9];

    ////////////////////////////////////////////////////////////////////////////////////
    // addressing
    wire [3:0] acc_bank = lit[7] ? dmx_pkg::ACCESS_HIGH_BANK : dmx_pkg::ACCESS_LOW_BANK;
    wire [3:0] bank = ir_q[8] ? bank_sel_q[3:0] : acc_bank;
    wire [11:0] file_addr = {bank, lit};
    wire [11:0] rd_addr = is_f2f ? ir_q[11:0] : file_addr;
    wire [11:0] wr_addr = dst_ok ? ir_q[11:0] : file_addr;
    wire need_read = is_fmv || is_f2f;
    wire rd_wreg = rd_addr == dmx_pkg::WREG_ADDR;
    wire wr_wreg = wr_addr == dmx_pkg::WREG_ADDR;
    wire [7:0] rd_val = rd_wreg ? w_q : DMEM_RDATA;
    wire file_wr = (is_fmv && dest_f) || is_sto || dst_ok;
    wire [7:0] wr_val = is_sto ? w_q : rd_q;
    wire w_wr = is_lit || (is_fmv && !dest_f) || (file_wr && wr_wreg);
    wire [7:0] w_val = is_lit ? lit : wr_val;

    assign FETCH_READY = q1 && run_q;
    assign DMEM_ADDR = q4 ? wr_addr : rd_addr;
    assign DMEM_RE = q2 && need_read && !rd_wreg;
    assign DMEM_WDATA = wdata_q;
    assign DMEM_WE = we_q;

    ////////////////////////////////////////////////////////////////////////////////////
    // fetch and read phases
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ir_q <= 16'h0000;
            iv_q <= 1'b0;
        end else if (q1) begin
            ir_q <= take ? FETCH_WORD : ir_q;
            iv_q <= take;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_q <= 8'h00;
        end else if (q2 && need_read) begin
            rd_q <= rd_val;
        end
    end

    // memory write staged in q3, seen only in q4
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            we_q <= 1'b0;
            wdata_q <= 8'h00;
        end else begin
            we_q <= q3 && file_wr && !wr_wreg;
            wdata_q <= q3 ? wr_val : wdata_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // write phase
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            w_q <= dmx_pkg::WREG_RST;
            bank_sel_q <= dmx_pkg::BANK_SEL_RST;
            status_q <= dmx_pkg::STATUS_RST;
        end else if (q4) begin
            w_q <= w_wr ? w_val : w_q;
            bank_sel_q <= is_bnk ? lit : bank_sel_q;
            if (is_fmv) begin
                status_q[dmx_pkg::STAT_Z_BIT] <= rd_q == 8'h00;
                status_q[dmx_pkg::STAT_N_BIT] <= rd_q[7];
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q <= dmx_pkg::ST_ONE;
            ptr_idx_q <= 2'h0;
        end else if (q4 && iv_q) begin
            if (is_ptr) begin
                st_q <= dmx_pkg::ST_PTR_LO;
                ptr_idx_q <= ir_q[5:4];
            end else if (is_f2f) begin
                st_q <= dmx_pkg::ST_F2F_DST;
            end else begin
                st_q <= dmx_pkg::ST_ONE;
            end
        end
    end

    // pointer index 3 matches no pointer and is dropped
    for (genvar i = 0; i < dmx_pkg::NUM_PTRS; i++) begin : g_ptr
        always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) begin
                ptr_hi_q[i] <= 4'h0;
                ptr_lo_q[i] <= 8'h00;
            end else if (q4) begin
                if (is_ptr && ir_q[5:4] == 2'(i)) begin
                    ptr_hi_q[i] <= ir_q[3:0];
                end
                if (ptr2_ok && ptr_idx_q == 2'(i)) begin
                    ptr_lo_q[i] <= lit;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            exec_cnt_q <= 32'h0000_0000;
            bad_cnt_q <= 32'h0000_0000;
        end else if (q4 && iv_q) begin
            exec_cnt_q <= known ? exec_cnt_q + 32'h1 : exec_cnt_q;
            bad_cnt_q <= known ? bad_cnt_q : bad_cnt_q + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // apb slave
    wire apb_setup = PSEL && !PENABLE;
    wire apb_wr = PSEL && PENABLE && PWRITE;
    wire hit_ctrl = PADDR == dmx_pkg::REG_CTRL;
    wire [31:0] rd_mux =
        hit_ctrl ? {31'h0, run_q} :
        PADDR == dmx_pkg::REG_WREG ? {24'h0, w_q} :
        PADDR == dmx_pkg::REG_BANK_SEL ? {24'h0, bank_sel_q} :
        PADDR == dmx_pkg::REG_STATUS ? {24'h0, status_q} :
        PADDR == dmx_pkg::REG_PTR0 ? {20'h0, ptr_hi_q[0], ptr_lo_q[0]} :
        PADDR == dmx_pkg::REG_PTR1 ? {20'h0, ptr_hi_q[1], ptr_lo_q[1]} :
        PADDR == dmx_pkg::REG_PTR2 ? {20'h0, ptr_hi_q[2], ptr_lo_q[2]} :
        PADDR == dmx_pkg::REG_EXEC_CNT ? exec_cnt_q :
        PADDR == dmx_pkg::REG_BAD_CNT ? bad_cnt_q : 32'h0000_0000;
    wire hit_any = hit_ctrl || PADDR == dmx_pkg::REG_WREG || PADDR == dmx_pkg::REG_BANK_SEL ||
        PADDR == dmx_pkg::REG_STATUS || PADDR == dmx_pkg::REG_PTR0 || PADDR == dmx_pkg::REG_PTR1 ||
        PADDR == dmx_pkg::REG_PTR2 || PADDR == dmx_pkg::REG_EXEC_CNT || PADDR == dmx_pkg::REG_BAD_CNT;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (apb_setup) begin
            prdata_q <= PWRITE ? 32'h0000_0000 : rd_mux;
            slverr_q <= !hit_any || (PWRITE && !hit_ctrl);
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            run_q <= dmx_pkg::CTRL_RUN_RST;
        end else if (apb_wr && hit_ctrl) begin
            run_q <= PWDATA[0];
        end
    end

    assign PREADY = 1'b1;
    assign PRDATA = prdata_q;
    assign PSLVERR = PSEL && PENABLE && slverr_q;

    ////////////////////////////////////////////////////////////////////////////////////
    // checks
    wire [7:0] ptr_lo_sel = ptr_lo_q[ptr_idx_q];
    wire [3:0] ptr_hi_sel = ptr_hi_q[ptr_idx_q];

    AST_FETCH_IN_Q1: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        FETCH_READY |-> phase == dmx_pkg::PH_Q1)
        else $error("fetch offered outside decode phase");
    AST_WE_ONLY_Q4: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        DMEM_WE |-> phase == dmx_pkg::PH_Q4 && $past(phase) == dmx_pkg::PH_Q3)
        else $error("memory write outside last phase");
    AST_LIT_LOAD: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (take && st_one && FETCH_WORD[15:8] == dmx_pkg::OP_LIT_LOAD) |->
        ##4 (w_q == $past(FETCH_WORD[7:0], 4) && status_q == $past(status_q, 4)))
        else $error("literal load did not reach working register");
    AST_BANK_LOAD: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (take && st_one && FETCH_WORD[15:8] == dmx_pkg::OP_BANK_LOAD) |->
        ##3 $stable(bank_sel_q) ##1 bank_sel_q == $past(FETCH_WORD[7:0], 4))
        else $error("bank load wrong value or early");
    AST_PTR_SEQ: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (take && st_one && FETCH_WORD[15:6] == dmx_pkg::OP_PTR_LOAD) |-> ##4 st_q == dmx_pkg::ST_PTR_LO)
        else $error("pointer load did not await second word");
    AST_PTR_LO: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && ptr2_ok && ptr_idx_q != 2'h3) |=> ptr_lo_sel == $past(lit) && st_q == dmx_pkg::ST_ONE)
        else $error("pointer low byte not written");
    AST_FMV_DEST: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && is_fmv && !dest_f) |=> w_q == $past(rd_q))
        else $error("file move did not write working register");
    AST_FMV_FLAGS: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && is_fmv) |=> status_q[dmx_pkg::STAT_Z_BIT] == ($past(rd_q) == 8'h00) &&
        status_q[dmx_pkg::STAT_N_BIT] == $past(rd_q[7]))
        else $error("file move flags wrong");
    AST_ACCESS_BANK: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q2 && is_fmv && !ir_q[8]) |-> DMEM_ADDR[11:8] == (ir_q[7] ? 4'hf : 4'h0))
        else $error("access bank not used for a=0");
    AST_F2F_NO_READ: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q2 && st_dst) |-> !DMEM_RE)
        else $error("dummy read in destination cycle");
    AST_F2F_WRITE: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && dst_ok && ir_q[11:0] != dmx_pkg::WREG_ADDR) |->
        DMEM_WE && DMEM_ADDR == ir_q[11:0] && DMEM_WDATA == rd_q)
        else $error("file-to-file destination write wrong");
    AST_F2F_WREG: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && dst_ok && ir_q[11:0] == dmx_pkg::WREG_ADDR) |=> w_q == $past(rd_q) && !$past(DMEM_WE))
        else $error("working register not written as destination");
    AST_STORE: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && is_sto && !wr_wreg) |-> DMEM_WE && DMEM_WDATA == w_q && $stable(status_q))
        else $error("store did not write working register value");

    // first words, stores, write-backs, stalls, flags and bad words
    AST_PTR_HI: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && is_ptr && ir_q[5:4] != 2'h3) |=>
        ptr_hi_sel == $past(ir_q[3:0]) && st_q == dmx_pkg::ST_PTR_LO)
        else $error("pointer high part not written");
    AST_FLAGS_KEPT: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && (is_ptr || ptr2_ok || is_bnk || is_lit || is_sto || is_f2f || dst_ok)) |=>
        $stable(status_q))
        else $error("flags changed by a flag-free move");
    AST_F2F_SRC_READ: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q2 && is_f2f && ir_q[11:0] != dmx_pkg::WREG_ADDR) |-> DMEM_RE && DMEM_ADDR == ir_q[11:0])
        else $error("file-to-file source not read in first cycle");
    AST_STORE_BANK: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && is_sto && ir_q[8] && !wr_wreg) |-> DMEM_ADDR == {bank_sel_q[3:0], lit})
        else $error("store ignored bank select");
    AST_FMV_BACK: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && is_fmv && dest_f && !wr_wreg) |-> DMEM_WE && DMEM_WDATA == rd_q && DMEM_ADDR == file_addr)
        else $error("file move did not write back");
    AST_F2F_STALL: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && st_dst && !iv_q) |=> st_q == dmx_pkg::ST_F2F_DST)
        else $error("file-to-file move left its destination wait");
    AST_PTR_WAIT: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && st_plo && !iv_q) |=> st_q == dmx_pkg::ST_PTR_LO)
        else $error("pointer load left its second-word wait");
    AST_BAD_COUNT: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (q4 && iv_q && !known) |=>
        bad_cnt_q == $past(bad_cnt_q) + 32'h1 && exec_cnt_q == $past(exec_cnt_q))
        else $error("bad word not counted");

    COV_F2F: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) q4 && dst_ok);
    COV_PTR: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) q4 && ptr2_ok);
    COV_FMV_BACK: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) q4 && is_fmv && dest_f);
    COV_STALL: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) q4 && st_dst && !iv_q);
    COV_PTR_DROP: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) q4 && is_ptr && ir_q[5:4] == 2'h3);
endmodule // data_move_instr_exec
`default_nettype wire

// File: rtl/dmx_phase_seq.sv
// four-phase instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module dmx_phase_seq (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // phase
    output logic [1:0] phase
);
    logic [1:0] phase_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= dmx_pkg::PH_Q1;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    assign phase = phase_q;

    AST_PHASE_ORDER: assert property (@(posedge clk) disable iff (!arst_n)
        phase_q == dmx_pkg::PH_Q4 |=> phase_q == dmx_pkg::PH_Q1)
        else $error("phase did not wrap from last to first");
endmodule // dmx_phase_seq
`default_nettype wire

// File: rtl/dmx_pkg.sv
// constants shared by the data-movement instruction executor
//
// Summary of operation
// - pointer load is two words: opcode, index, high literal nibble; then 1111 0000, low byte.
// - index picks pointer 0..2; first cycle writes high nibble, second low byte; flags untouched.
// - file move reads a file register; d=0 writes the working register, d=1 writes it back.
// - file move sets negative and zero from the moved value; other flags keep their value.
// - single-word file address is 8 bits; a=0 uses access bank, a=1 uses bank select.
// - file-to-file move is two words: 1100 plus source, then 1111 plus destination.
// - file-to-file move reaches all of 000h..FFFh without the bank select register.
// - working register may be source or destination of the file-to-file move.
// - file-to-file move: first cycle reads source; second cycle no read, writes destination.
// - bank load writes its 8-bit literal into bank select in one cycle; flags untouched.
// - literal load writes its 8-bit literal into the working register; flags untouched.
// - store copies working register to file register, honours access bit, flags untouched.
package dmx_pkg;

    ////////////////////////////////////////////////////////////////////////////////////
    // phases of one instruction cycle
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////////
    // opcode prefixes
    localparam logic [9:0] OP_PTR_LOAD = 10'h3b8;
    localparam logic [7:0] OP_PTR_LOAD2 = 8'hf0;
    localparam logic [5:0] OP_FILE_MOVE = 6'h14;
    localparam logic [3:0] OP_F2F_SRC = 4'hc;
    localparam logic [3:0] OP_F2F_DST = 4'hf;
    localparam logic [7:0] OP_BANK_LOAD = 8'h01;
    localparam logic [7:0] OP_LIT_LOAD = 8'h0e;
    localparam logic [6:0] OP_ACC_STORE = 7'h37;

    ////////////////////////////////////////////////////////////////////////////////////
    // data space
    localparam logic [11:0] WREG_ADDR = 12'hfe8;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam int NUM_PTRS = 3;

    ////////////////////////////////////////////////////////////////////////////////////
    // status flag positions and reset values
    localparam int STAT_Z_BIT = 2;
    localparam int STAT_N_BIT = 4;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [7:0] BANK_SEL_RST = 8'h00;
    localparam logic CTRL_RUN_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////////
    // apb register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WREG = 8'h04;
    localparam logic [7:0] REG_BANK_SEL = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_PTR0 = 8'h10;
    localparam logic [7:0] REG_PTR1 = 8'h14;
    localparam logic [7:0] REG_PTR2 = 8'h18;
    localparam logic [7:0] REG_EXEC_CNT = 8'h1c;
    localparam logic [7:0] REG_BAD_CNT = 8'h20;

    typedef enum logic [1:0] {ST_ONE, ST_PTR_LO, ST_F2F_DST} stage_t;

endpackage
